// ==== hdl/efp_ctrl.sv ====
// Encoder and pulse-train feedback front end with position regulator
`timescale 1ns/1ps
module efp_ctrl
  import efp_pkg::*;
#(
  parameter int SPEED_WIN_CYC = SPEED_WIN_DFLT
)
(
  // Clock and reset
  input  wire logic        clock_in,
  input  wire logic        nrst_in,
  // Register port
  input  wire logic [4:0]  addr_in,
  input  wire logic [31:0] wdata_in,
  input  wire logic        wr_in,
  input  wire logic        rd_in,
  output logic      [31:0] rdata_out,
  // Encoder pins
  input  wire logic        enc_a_in,
  input  wire logic        enc_b_in,
  // Drive side
  input  wire logic [15:0] speed_cmd_in,
  input  wire logic [15:0] expected_speed_in,
  // Feedback results
  output logic             fb_enable_out,
  output logic      [1:0]  route_out,
  output logic      [15:0] speed_ref_out,
  output logic      [15:0] pid_fb_out,
  output logic      [15:0] trim_out,
  output logic             slip_bypass_out,
  // Position results
  output logic             position_enable_out,
  output logic      [31:0] position_out,
  output logic             at_home_out,
  output logic             at_position_out,
  output logic             move_fwd_out,
  output logic             move_rev_out,
  // Interrupt
  output logic             irq_out
);

  // ---------------------------------------------------------------
  // Helpers
  // ---------------------------------------------------------------
  function automatic logic [33:0] efp_abs34(input logic signed [33:0] v);
    efp_abs34 = v[33] ? 34'(-v) : 34'(v);
  endfunction

  function automatic logic sel_hits(input logic [4:0] s, input logic [4:0] code);
    sel_hits = (s == code);
  endfunction

  // ---------------------------------------------------------------
  // Configuration registers
  // ---------------------------------------------------------------
  logic [2:0]  fb_type_reg;
  logic        rev_inhibit_reg;
  logic [4:0]  sref1_reg;
  logic [4:0]  sref2_reg;
  logic [4:0]  sref3_reg;
  logic [3:0]  pid_sel_reg;
  logic [15:0] kp_reg;
  logic [15:0] ki_reg;
  logic [15:0] ppr_reg;
  logic [15:0] cpu_reg;
  logic [15:0] tol_reg;
  logic [15:0] loss_reg;
  logic [2:0]  tsel_reg;
  logic [ST_W-1:0] stat_reg;
  logic [ST_W-1:0] irqen_reg;
  logic [15:0] tgt_reg [N_TARGETS];

  wire wr_ctrl   = wr_in && (addr_in == REG_CTRL);
  wire wr_sref   = wr_in && (addr_in == REG_SREF);
  wire wr_pidsel = wr_in && (addr_in == REG_PIDSEL);
  wire wr_gain   = wr_in && (addr_in == REG_GAIN);
  wire wr_ppr    = wr_in && (addr_in == REG_PPR);
  wire wr_cpu    = wr_in && (addr_in == REG_CPU);
  wire wr_tol    = wr_in && (addr_in == REG_TOL);
  wire wr_loss   = wr_in && (addr_in == REG_LOSS);
  wire wr_tsel   = wr_in && (addr_in == REG_TSEL);
  wire wr_clr    = wr_in && (addr_in == REG_CLR);
  wire wr_irqen  = wr_in && (addr_in == REG_IRQEN);

  always_ff @(posedge clock_in or negedge nrst_in)
  begin
    if (!nrst_in)
    begin
      fb_type_reg     <= FB_NONE;
      rev_inhibit_reg <= 1'b0;
      sref1_reg       <= 5'h00;
      sref2_reg       <= 5'h00;
      sref3_reg       <= 5'h00;
      pid_sel_reg     <= 4'h0;
      kp_reg          <= 16'h0000;
      ki_reg          <= 16'h0000;
      ppr_reg         <= PPR_RST;
      cpu_reg         <= CPU_RST;
      tol_reg         <= 16'h0000;
      loss_reg        <= LOSS_RST;
      tsel_reg        <= 3'h0;
      irqen_reg       <= '0;
    end
    else
    begin
      if (wr_ctrl)   {rev_inhibit_reg, fb_type_reg} <= wdata_in[3:0];
      if (wr_sref)   {sref3_reg, sref2_reg, sref1_reg} <=
                       {wdata_in[20:16], wdata_in[12:8], wdata_in[4:0]};
      if (wr_pidsel) pid_sel_reg <= wdata_in[3:0];
      if (wr_gain)   {ki_reg, kp_reg} <= wdata_in;
      if (wr_ppr)    ppr_reg <= wdata_in[15:0];
      if (wr_cpu)    cpu_reg <= wdata_in[15:0];
      if (wr_tol)    tol_reg <= wdata_in[15:0];
      if (wr_loss)   loss_reg <= wdata_in[15:0];
      if (wr_tsel)   tsel_reg <= wdata_in[2:0];
      if (wr_irqen)  irqen_reg <= wdata_in[ST_W-1:0];
    end
  end

  // Target position table
  genvar gi;
  generate
    for (gi = 0; gi < N_TARGETS; gi++)
    begin : g_tgt
      wire wr_tgt = wr_in && (addr_in == 5'(REG_TGT0 + gi));
      always_ff @(posedge clock_in or negedge nrst_in)
      begin
        if (!nrst_in)
          tgt_reg[gi] <= 16'h0000;
        else if (wr_tgt)
          tgt_reg[gi] <= wdata_in[15:0];
      end
    end
  endgenerate

  // ---------------------------------------------------------------
  // Mode decode
  // ---------------------------------------------------------------
  wire fb_en      = (fb_type_reg != FB_NONE);
  wire quad_mode  = (fb_type_reg == FB_QUAD) || (fb_type_reg == FB_QUAD_CHK);
  wire chan_mode  = (fb_type_reg == FB_PULSE) || (fb_type_reg == FB_SINGLE) ||
                    (fb_type_reg == FB_SINGLE_CHK);
  wire scaled     = (fb_type_reg == FB_SINGLE) || (fb_type_reg == FB_SINGLE_CHK) ||
                    quad_mode;

  // ---------------------------------------------------------------
  // Pin synchronisers and edge detect
  // ---------------------------------------------------------------
  logic a_s1_reg, a_s2_reg, a_p_reg;
  logic b_s1_reg, b_s2_reg, b_p_reg;

  always_ff @(posedge clock_in or negedge nrst_in)
  begin
    if (!nrst_in)
      {a_s1_reg, a_s2_reg, a_p_reg, b_s1_reg, b_s2_reg, b_p_reg} <= 6'h00;
    else
      {a_s1_reg, a_s2_reg, a_p_reg, b_s1_reg, b_s2_reg, b_p_reg} <=
        {enc_a_in, a_s1_reg, a_s2_reg, enc_b_in, b_s1_reg, b_s2_reg};
  end

  wire chg_a    = a_s2_reg ^ a_p_reg;
  wire chg_b    = b_s2_reg ^ b_p_reg;
  // Channel B only matters in quadrature; A rising edge otherwise
  wire quad_ok  = quad_mode && (chg_a ^ chg_b);
  wire quad_up  = a_s2_reg ^ b_p_reg;
  wire chan_ok  = chan_mode && chg_a && a_s2_reg;
  wire cnt_edge = fb_en && (quad_ok || chan_ok);

  // ---------------------------------------------------------------
  // Edge rate check
  // ---------------------------------------------------------------
  logic [GAP_W-1:0] gap_reg;
  wire  [GAP_W-1:0] min_gap = quad_mode ? GAP_W'(QUAD_MIN_CYC) : GAP_W'(PULSE_MIN_CYC);
  wire rate_evt = cnt_edge && (gap_reg < min_gap);

  always_ff @(posedge clock_in or negedge nrst_in)
  begin
    if (!nrst_in)
      gap_reg <= '1;
    else if (cnt_edge)
      gap_reg <= '0;
    else if (gap_reg != '1)
      gap_reg <= gap_reg + 1'b1;
  end

  // ---------------------------------------------------------------
  // Position counter and speed window
  // ---------------------------------------------------------------
  logic signed [31:0] pos_reg;
  logic signed [16:0] acc_reg;
  logic signed [16:0] raw_reg;
  logic [31:0]        win_reg;
  logic [1:0]         win_d_reg;
  wire                win_end = (win_reg == 32'(SPEED_WIN_CYC - 1));
  wire signed [1:0]   delta   = (quad_mode && !quad_up) ? -2'sd1 : 2'sd1;

  always_ff @(posedge clock_in or negedge nrst_in)
  begin
    if (!nrst_in)
    begin
      pos_reg   <= '0;
      acc_reg   <= '0;
      raw_reg   <= '0;
      win_reg   <= '0;
      win_d_reg <= 2'h0;
    end
    else
    begin
      win_d_reg <= {win_d_reg[0], win_end};
      win_reg   <= win_end ? '0 : win_reg + 1'b1;
      if (quad_ok && fb_en)
        pos_reg <= pos_reg + 32'(delta);
      if (win_end)
      begin
        raw_reg <= fb_en ? acc_reg + 17'(cnt_edge ? delta : 2'sd0) : '0;
        acc_reg <= '0;
      end
      else if (cnt_edge)
        acc_reg <= acc_reg + 17'(delta);
    end
  end

  // ---------------------------------------------------------------
  // Speed scaling
  // ---------------------------------------------------------------
  wire [16:0] raw_mag = raw_reg[16] ? 17'(-raw_reg) : 17'(raw_reg);
  wire [17:0] den     = quad_mode ? {ppr_reg, 2'b00} : {2'b00, ppr_reg};
  wire [31:0] num     = {7'h00, raw_mag, 8'h00};
  wire [31:0] quo     = (den == '0) ? '0 : num / {14'h0000, den};
  // Pulse train stays raw; single and quadrature use scaling
  wire [15:0] mag     = scaled ? quo[15:0] : raw_mag[15:0];
  wire signed [15:0] speed_fb = (quad_mode && raw_reg[16]) ? -$signed(mag) : $signed(mag);

  // ---------------------------------------------------------------
  // Loss and wiring checks
  // ---------------------------------------------------------------
  logic signed [15:0] speed_reg;
  wire signed [15:0] exp_s   = $signed(expected_speed_in);
  wire signed [15:0] exp_cmp = quad_mode ? exp_s : (exp_s < 0 ? -exp_s : exp_s);
  wire [33:0] spd_diff = efp_abs34(34'(speed_reg) - 34'(exp_cmp));
  wire mismatch  = spd_diff > 34'(loss_reg);
  wire big_meas  = efp_abs34(34'(speed_reg)) > 34'(loss_reg);
  wire big_exp   = efp_abs34(34'(exp_s)) > 34'(loss_reg);
  wire reversed  = big_meas && big_exp && (speed_reg[15] != exp_s[15]);
  wire chk_now   = win_d_reg[1];
  wire loss_evt  = chk_now && mismatch && !reversed &&
                   ((fb_type_reg == FB_SINGLE_CHK) || (fb_type_reg == FB_QUAD_CHK));
  wire wire_evt  = chk_now && reversed && (fb_type_reg == FB_QUAD_CHK);

  // ---------------------------------------------------------------
  // Feedback routing and speed trim
  // ---------------------------------------------------------------
  wire sref_pick = sel_hits(sref1_reg, SREF_ENCODER) || sel_hits(sref2_reg, SREF_ENCODER) ||
                   sel_hits(sref3_reg, SREF_ENCODER) ||
                   sel_hits(sref1_reg, SREF_POSITIONING);
  efp_route_t route;
  assign route = !fb_en          ? RT_NONE      :
                 sref_pick       ? RT_SPEED_REF :
                 (|pid_sel_reg)  ? RT_PID       :
                                   RT_TRIM;

  logic signed [31:0] integ_reg;
  wire signed [16:0] err   = 17'($signed(speed_cmd_in)) - 17'(speed_reg);
  wire signed [33:0] p_trm = 34'(err) * 34'($signed({1'b0, kp_reg}));
  wire signed [33:0] i_inc = 34'(err) * 34'($signed({1'b0, ki_reg}));
  wire signed [33:0] trim  = (p_trm + 34'(integ_reg)) >>> GAIN_SHIFT;

  always_ff @(posedge clock_in or negedge nrst_in)
  begin
    if (!nrst_in)
      integ_reg <= '0;
    else if (route != RT_TRIM)
      integ_reg <= '0;
    else if (chk_now)
      integ_reg <= integ_reg + 32'(i_inc);
  end

  // ---------------------------------------------------------------
  // Position regulator
  // ---------------------------------------------------------------
  wire pos_en = sel_hits(sref1_reg, SREF_POSITIONING) && (fb_type_reg == FB_QUAD);
  wire [31:0] pos_mag  = pos_reg[31] ? 32'(-pos_reg) : 32'(pos_reg);
  wire [31:0] unit_mag = (cpu_reg == '0) ? '0 : pos_mag / {16'h0000, cpu_reg};
  wire signed [31:0] units = pos_reg[31] ? -$signed(unit_mag) : $signed(unit_mag);
  wire signed [33:0] tgt_cnt = 34'($signed(tgt_reg[tsel_reg])) *
                               34'($signed({1'b0, cpu_reg}));
  wire signed [33:0] pos_err = tgt_cnt - 34'(pos_reg);
  // Tolerance only drives the flags, never the move decision
  wire in_tol  = efp_abs34(pos_err) <= 34'(tol_reg);
  wire at_home = efp_abs34(34'(pos_reg)) <= 34'(tol_reg);
  wire want_fwd = pos_en && (pos_err > 0);
  wire want_rev = pos_en && (pos_err < 0) && !rev_inhibit_reg;
  logic arrive_reg;
  wire arrive_evt = pos_en && in_tol && !arrive_reg;

  // ---------------------------------------------------------------
  // Status and interrupt
  // ---------------------------------------------------------------
  wire [ST_W-1:0] evts = {arrive_evt, rate_evt, wire_evt, loss_evt};
  wire [ST_W-1:0] stat_next = (stat_reg & ~(wr_clr ? wdata_in[ST_W-1:0] : '0)) | evts;

  // ---------------------------------------------------------------
  // Read decode
  // ---------------------------------------------------------------
  wire [31:0] rd_mux =
    (addr_in == REG_CTRL)   ? {28'h0000000, rev_inhibit_reg, fb_type_reg} :
    (addr_in == REG_SREF)   ? {11'h000, sref3_reg, 3'h0, sref2_reg, 3'h0, sref1_reg} :
    (addr_in == REG_PIDSEL) ? {28'h0000000, pid_sel_reg} :
    (addr_in == REG_GAIN)   ? {ki_reg, kp_reg} :
    (addr_in == REG_PPR)    ? {16'h0000, ppr_reg} :
    (addr_in == REG_CPU)    ? {16'h0000, cpu_reg} :
    (addr_in == REG_TOL)    ? {16'h0000, tol_reg} :
    (addr_in == REG_LOSS)   ? {16'h0000, loss_reg} :
    (addr_in == REG_TSEL)   ? {29'h00000000, tsel_reg} :
    (addr_in == REG_POS)    ? pos_reg :
    (addr_in == REG_UNITS)  ? units :
    (addr_in == REG_SPEED)  ? {{16{speed_reg[15]}}, speed_reg} :
    (addr_in == REG_STAT)   ? {28'h0000000, stat_reg} :
    (addr_in == REG_IRQEN)  ? {28'h0000000, irqen_reg} :
    (addr_in[4] == 1'b1 && addr_in[3] == 1'b0) ? {16'h0000, tgt_reg[addr_in[2:0]]} :
    32'h00000000;

  // ---------------------------------------------------------------
  // Output and status registers
  // ---------------------------------------------------------------
  always_ff @(posedge clock_in or negedge nrst_in)
  begin
    if (!nrst_in)
    begin
      speed_reg           <= '0;
      stat_reg            <= '0;
      arrive_reg          <= 1'b0;
      rdata_out           <= '0;
      fb_enable_out       <= 1'b0;
      route_out           <= RT_NONE;
      speed_ref_out       <= '0;
      pid_fb_out          <= '0;
      trim_out            <= '0;
      slip_bypass_out     <= 1'b0;
      position_enable_out <= 1'b0;
      position_out        <= '0;
      at_home_out         <= 1'b0;
      at_position_out     <= 1'b0;
      move_fwd_out        <= 1'b0;
      move_rev_out        <= 1'b0;
      irq_out             <= 1'b0;
    end
    else
    begin
      speed_reg           <= speed_fb;
      stat_reg            <= stat_next;
      arrive_reg          <= pos_en && in_tol;
      rdata_out           <= rd_in ? rd_mux : '0;
      fb_enable_out       <= fb_en;
      route_out           <= route;
      speed_ref_out       <= (route == RT_SPEED_REF) ? speed_reg : '0;
      pid_fb_out          <= (route == RT_PID) ? speed_reg : '0;
      trim_out            <= (route == RT_TRIM) ? trim[15:0] : '0;
      slip_bypass_out     <= (route == RT_TRIM);
      position_enable_out <= pos_en;
      position_out        <= units;
      at_home_out         <= pos_en && at_home;
      at_position_out     <= pos_en && in_tol;
      move_fwd_out        <= want_fwd;
      move_rev_out        <= want_rev;
      irq_out             <= |(stat_next & irqen_reg);
    end
  end

endmodule // efp_ctrl

// ==== hdl/efp_pkg.sv ====
// Constants, register map and types of the encoder feedback and position block
//
// How it works
// - Nonzero feedback type enables feedback processing
// - Pulse-train input accepts up to 100 kHz
// - Quadrature input decodes up to 250 kHz
// - Speed reference selection takes feedback first
// - Otherwise PID selection takes the feedback
// - Otherwise PI speed trim, slip compensation bypassed
// - Channel A all modes, B quadrature only
// - Feedback type codes zero through five
// - Pulse/single give magnitude; single uses scaling
// - Single check faults on speed mismatch unless both speeds pass the loss level with opposite signs
// - Quadrature check faults on speed mismatch
// - Quadrature check faults on reversed wiring
// - Eight target positions at most
// - Position units are counts over counts-per-unit
// - Arrival flags use raw pulse tolerance only
package efp_pkg;

  // ---------------------------------------------------------------
  // Timing
  // ---------------------------------------------------------------
  localparam int CLK_HZ          = 40_000_000;
  localparam int PULSE_MAX_HZ    = 100_000;
  localparam int QUAD_MAX_HZ     = 250_000;
  localparam int PULSE_MIN_CYC   = (CLK_HZ + PULSE_MAX_HZ - 1) / PULSE_MAX_HZ;
  localparam int QUAD_MIN_CYC    = (CLK_HZ + QUAD_MAX_HZ - 1) / QUAD_MAX_HZ;
  localparam int SPEED_WIN_US    = 1000;
  localparam int SPEED_WIN_DFLT  = CLK_HZ / 1_000_000 * SPEED_WIN_US;
  localparam int GAP_W           = 16;
  localparam int SPD_FRAC        = 8;
  localparam int GAIN_SHIFT      = 8;

  // ---------------------------------------------------------------
  // Feedback type codes
  // ---------------------------------------------------------------
  localparam logic [2:0] FB_NONE       = 3'h0;
  localparam logic [2:0] FB_PULSE      = 3'h1;
  localparam logic [2:0] FB_SINGLE     = 3'h2;
  localparam logic [2:0] FB_SINGLE_CHK = 3'h3;
  localparam logic [2:0] FB_QUAD       = 3'h4;
  localparam logic [2:0] FB_QUAD_CHK   = 3'h5;

  // Speed reference select codes
  localparam logic [4:0] SREF_ENCODER     = 5'h0A;
  localparam logic [4:0] SREF_POSITIONING = 5'h10;

  // ---------------------------------------------------------------
  // Register indices
  // ---------------------------------------------------------------
  localparam logic [4:0] REG_CTRL   = 5'h00;
  localparam logic [4:0] REG_SREF   = 5'h01;
  localparam logic [4:0] REG_PIDSEL = 5'h02;
  localparam logic [4:0] REG_GAIN   = 5'h03;
  localparam logic [4:0] REG_PPR    = 5'h04;
  localparam logic [4:0] REG_CPU    = 5'h05;
  localparam logic [4:0] REG_TOL    = 5'h06;
  localparam logic [4:0] REG_LOSS   = 5'h07;
  localparam logic [4:0] REG_TSEL   = 5'h08;
  localparam logic [4:0] REG_POS    = 5'h09;
  localparam logic [4:0] REG_UNITS  = 5'h0A;
  localparam logic [4:0] REG_SPEED  = 5'h0B;
  localparam logic [4:0] REG_STAT   = 5'h0C;
  localparam logic [4:0] REG_CLR    = 5'h0D;
  localparam logic [4:0] REG_IRQEN  = 5'h0E;
  localparam logic [4:0] REG_TGT0   = 5'h10;
  localparam int         N_TARGETS  = 8;

  // Reset values
  localparam logic [15:0] PPR_RST  = 16'h0400;
  localparam logic [15:0] CPU_RST  = 16'h0001;
  localparam logic [15:0] LOSS_RST = 16'h0010;

  // Status bit positions
  localparam int ST_LOSS   = 0;
  localparam int ST_WIRING = 1;
  localparam int ST_RATE   = 2;
  localparam int ST_ARRIVE = 3;
  localparam int ST_W      = 4;

  // Feedback destination
  typedef enum logic [1:0] {RT_NONE, RT_SPEED_REF, RT_PID, RT_TRIM} efp_route_t;

endpackage

// ==== test/efp_enc_model.sv ====
// Quadrature encoder model driving channels A and B
`timescale 1ns/1ps
module efp_enc_model
(
  // Clock and reset
  input  wire logic clock_in,
  input  wire logic nrst_in,
  // Step request
  input  wire logic step_in,
  input  wire logic rev_in,
  // Encoder pins
  output logic      enc_a_out,
  output logic      enc_b_out
);
  logic [1:0] ph_reg;

  // ---------------------------------------------------------------
  // Gray phase, A leads B going forward
  // ---------------------------------------------------------------
  always_ff @(posedge clock_in or negedge nrst_in)
  begin
    if (!nrst_in)
      ph_reg <= 2'h0;
    else if (step_in)
      ph_reg <= rev_in ? ph_reg - 2'h1 : ph_reg + 2'h1;
  end

  assign enc_a_out = ph_reg[1] ^ ph_reg[0];
  assign enc_b_out = ph_reg[1];
endmodule // efp_enc_model

// ==== test/efp_ctrl_chk.sv ====
// Port checker of the feedback and position block
`timescale 1ns/1ps
module efp_ctrl_chk
  import efp_pkg::*;
#(
  parameter int SPEED_WIN_CYC = SPEED_WIN_DFLT
)
(
  input wire logic        clock_in,
  input wire logic        nrst_in,
  input wire logic        rd_in,
  input wire logic [31:0] rdata_out,
  input wire logic        fb_enable_out,
  input wire logic [1:0]  route_out,
  input wire logic [15:0] speed_ref_out,
  input wire logic [15:0] pid_fb_out,
  input wire logic [15:0] trim_out,
  input wire logic        slip_bypass_out,
  input wire logic        position_enable_out,
  input wire logic        at_home_out,
  input wire logic        at_position_out,
  input wire logic        move_fwd_out,
  input wire logic        move_rev_out
);
  default clocking cb @(posedge clock_in); endclocking
  default disable iff (!nrst_in);

  sequence s_no_rd;
    !rd_in;
  endsequence
  sequence s_arrived;
    at_home_out || at_position_out;
  endsequence

  property p_rd_zero;  s_no_rd |=> rdata_out == 32'h0; endproperty
  property p_fb;  !fb_enable_out |-> route_out == 2'h0; endproperty
  property p_sref;  route_out != 2'h1 |-> speed_ref_out == 16'h0; endproperty
  property p_pid;  route_out != 2'h2 |-> pid_fb_out == 16'h0; endproperty
  property p_trim;  route_out != 2'h3 |-> trim_out == 16'h0; endproperty
  property p_slip;  slip_bypass_out == (route_out == 2'h3); endproperty
  property p_posen;  position_enable_out |-> fb_enable_out && route_out == 2'h1; endproperty
  property p_arrive;  s_arrived |-> position_enable_out; endproperty
  property p_move;  move_fwd_out |-> !move_rev_out; endproperty

  a_rd_zero: assert property (p_rd_zero) else $error("read data not zero");
  a_fb:      assert property (p_fb) else $error("route without feedback");
  a_sref:    assert property (p_sref) else $error("speed ref leak");
  a_pid:     assert property (p_pid) else $error("pid leak");
  a_trim:    assert property (p_trim) else $error("trim leak");
  a_slip:    assert property (p_slip) else $error("slip bypass wrong");
  a_posen:   assert property (p_posen) else $error("position enable wrong");
  a_arrive:  assert property (p_arrive) else $error("arrival while off");
  a_move:    assert property (p_move) else $error("both moves on");
endmodule // efp_ctrl_chk

bind efp_ctrl efp_ctrl_chk #(.SPEED_WIN_CYC(SPEED_WIN_CYC)) u_efp_ctrl_chk (
  .clock_in(clock_in), .nrst_in(nrst_in), .rd_in(rd_in), .rdata_out(rdata_out),
  .fb_enable_out(fb_enable_out), .route_out(route_out), .speed_ref_out(speed_ref_out),
  .pid_fb_out(pid_fb_out), .trim_out(trim_out), .slip_bypass_out(slip_bypass_out),
  .position_enable_out(position_enable_out), .at_home_out(at_home_out),
  .at_position_out(at_position_out), .move_fwd_out(move_fwd_out),
  .move_rev_out(move_rev_out));

// ==== test/tb_efp_ctrl.sv ====
// Self-checking testbench of the feedback and position block
`timescale 1ns/1ps
module tb_efp_ctrl;
  import efp_pkg::*;
  logic clock_in, nrst_in, wr_in, rd_in, enc_a, enc_b, step, rev, rd_q;
  logic [4:0] addr_in;
  logic [31:0] wdata_in, rdata_out, pos, tg[8];
  logic [15:0] speed_cmd_in, expected_speed_in, sref_o, pid_o, trim_o;
  logic [1:0] route_out;
  logic fb_en, slip, pos_en, home, arrive, mfwd, mrev, irq;
  logic [63:0] q[$];
  logic [63:0] ent;
  int err_total, n_compared, cyc, seed, i;
  logic [31:0] sr[5];
  logic [31:0] ps[5];

  efp_ctrl #(.SPEED_WIN_CYC(400)) u_efp_ctrl (.clock_in(clock_in), .nrst_in(nrst_in),
    .addr_in(addr_in), .wdata_in(wdata_in), .wr_in(wr_in), .rd_in(rd_in),
    .rdata_out(rdata_out), .enc_a_in(enc_a), .enc_b_in(enc_b), .speed_cmd_in(speed_cmd_in),
    .expected_speed_in(expected_speed_in), .fb_enable_out(fb_en), .route_out(route_out),
    .speed_ref_out(sref_o), .pid_fb_out(pid_o), .trim_out(trim_o), .slip_bypass_out(slip),
    .position_enable_out(pos_en), .position_out(pos), .at_home_out(home),
    .at_position_out(arrive), .move_fwd_out(mfwd), .move_rev_out(mrev), .irq_out(irq));
  efp_enc_model u_efp_enc_model (.clock_in(clock_in), .nrst_in(nrst_in), .step_in(step),
    .rev_in(rev), .enc_a_out(enc_a), .enc_b_out(enc_b));

  // ---------------------------------------------------------------
  // Clock, timeout, result monitor
  // ---------------------------------------------------------------
  initial
  begin
    clock_in = 1'b0;
    forever #12.5 clock_in = ~clock_in;
  end
  always @(posedge clock_in)
  begin
    rd_q <= rd_in;
    cyc = cyc + 1;
    if (cyc == 20000)
    begin
      err_total = err_total + 1;
      close_out();
    end
  end
  always @(negedge clock_in)
    if (rd_q === 1'b1)
    begin
      ent = q.pop_front();
      cmp(rdata_out & ent[63:32], ent[31:0]);
    end

  task automatic cmp(input logic [31:0] g, input logic [31:0] e);
    n_compared = n_compared + 1;
    if (g !== e)
    begin
      err_total = err_total + 1;
      $display("mismatch t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask
  task automatic wr(input logic [4:0] a, input logic [31:0] d);
    addr_in <= a;
    wdata_in <= d;
    wr_in <= 1'b1;
    rd_in <= 1'b0;
    @(posedge clock_in);
  endtask
  task automatic rd(input logic [4:0] a, input logic [31:0] m, input logic [31:0] e);
    q.push_back({m, e});
    addr_in <= a;
    rd_in <= 1'b1;
    wr_in <= 1'b0;
    @(posedge clock_in);
  endtask
  task automatic wt(input int n);
    wr_in <= 1'b0;
    rd_in <= 1'b0;
    repeat (n) @(posedge clock_in);
    #1;
  endtask
  task automatic steps(input int n, input logic r, input int gap);
    repeat (n)
    begin
      step <= 1'b1;
      rev <= r;
      @(posedge clock_in);
      step <= 1'b0;
      repeat (gap - 1) @(posedge clock_in);
    end
  endtask
  task automatic close_out();
    $display("compared %0d mismatches %0d", n_compared, err_total);
    if (err_total == 0 && n_compared > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask

  // ---------------------------------------------------------------
  // Main sequence
  // ---------------------------------------------------------------
  initial
  begin
    seed = 32'h01c8ec44;
    {err_total, n_compared, cyc} = '0;
    {nrst_in, wr_in, rd_in, step, rev, rd_q} = '0;
    addr_in = 5'h00;
    wdata_in = 32'h0;
    expected_speed_in = 16'h0000;
    speed_cmd_in = $random(seed);
    sr = '{32'h0000000A, 32'h00000A00, 32'h000A0000, 32'h0, 32'h0};
    ps = '{32'h0, 32'h1, 32'h0, 32'h1, 32'h0};
    repeat (2) @(posedge clock_in);
    nrst_in <= 1'b1;
    @(posedge clock_in);
    rd(REG_CTRL, 32'hFFFFFFFF, 32'h0);
    rd(REG_PPR, 32'hFFFFFFFF, 32'h00000400);
    rd(REG_CPU, 32'hFFFFFFFF, 32'h00000001);
    rd(REG_LOSS, 32'hFFFFFFFF, 32'h00000010);
    rd(REG_CLR, 32'hFFFFFFFF, 32'h0);
    rd(5'h1F, 32'hFFFFFFFF, 32'h0);
    wt(2);
    $display("test reset done");
    for (i = 0; i < N_TARGETS; i++)
    begin
      tg[i] = $random(seed) & 32'h00007FFF;
      wr(5'(REG_TGT0 + i), tg[i]);
    end
    wr(REG_POS, 32'h00000055);
    wr(5'h0F, 32'h00000055);
    for (i = 0; i < N_TARGETS; i++)
      rd(5'(REG_TGT0 + i), 32'hFFFFFFFF, tg[i]);
    rd(REG_POS, 32'hFFFFFFFF, 32'h0);
    rd(5'h0F, 32'hFFFFFFFF, 32'h0);
    wt(2);
    $display("test registers done");
    for (i = 0; i < 6; i++)
    begin
      wr(REG_CTRL, i);
      wt(3);
      cmp({31'h0, fb_en}, {31'h0, i != 0});
      cmp({30'h0, route_out}, (i != 0) ? 32'h3 : 32'h0);
      cmp({31'h0, slip}, {31'h0, i != 0});
    end
    $display("test types done");
    wr(REG_CTRL, FB_QUAD);
    for (i = 0; i < 5; i++)
    begin
      wr(REG_SREF, sr[i]);
      wr(REG_PIDSEL, ps[i]);
      wt(3);
      cmp({30'h0, route_out}, (i < 3) ? 32'h1 : 32'h3 - ps[i]);
    end
    $display("test priority done");
    wr(REG_SREF, SREF_POSITIONING);
    wr(REG_PIDSEL, 32'h0);
    wr(REG_CPU, 32'h1);
    wt(3);
    cmp({31'h0, pos_en}, 32'h1);
    i = 8 + 2 * ($random(seed) & 3);
    steps(i, 1'b0, 200);
    steps(2, 1'b1, 200);
    wt(6);
    cmp(pos, i - 2);
    rd(REG_POS, 32'hFFFFFFFF, i - 2);
    wr(REG_CPU, 32'h2);
    wr(REG_TOL, i - 2);
    wt(4);
    cmp(pos, (i - 2) / 2);
    cmp({31'h0, home}, 32'h1);
    rd(REG_UNITS, 32'hFFFFFFFF, (i - 2) / 2);
    wr(REG_TOL, 32'h1);
    wr(5'(REG_TGT0 + 7), (i - 2) / 2 + 1);
    wr(REG_TSEL, 32'h7);
    wt(4);
    cmp({31'h0, home}, 32'h0);
    cmp({31'h0, arrive}, 32'h0);
    wr(REG_TOL, 32'h2);
    wt(4);
    cmp({31'h0, arrive}, 32'h1);
    cmp({30'h0, mfwd, mrev}, 32'h2);
    $display("test position done");
    wr(REG_IRQEN, 32'h0);
    wr(REG_CLR, 32'hF);
    wt(1);
    steps(4, 1'b0, 20);
    wt(6);
    cmp({31'h0, irq}, 32'h0);
    rd(REG_STAT, 32'h4, 32'h4);
    wr(REG_IRQEN, 32'h4);
    wt(2);
    cmp({31'h0, irq}, 32'h1);
    wr(REG_CLR, 32'h4);
    wt(2);
    cmp({31'h0, irq}, 32'h0);
    rd(REG_STAT, 32'h4, 32'h0);
    wt(2);
    $display("test rate done");
    wr(REG_SREF, 32'h0);
    wr(REG_PPR, 32'h1);
    expected_speed_in <= 16'h0100;
    for (i = 3; i < 6; i++)
    begin
      wr(REG_CTRL, i);
      wr(REG_CLR, 32'hF);
      wt(1000);
      rd(REG_STAT, 32'h1, {31'h0, i != 4});
    end
    wr(REG_CLR, 32'hF);
    wt(1);
    steps(12, 1'b1, 180);
    rd(REG_STAT, 32'h2, 32'h2);
    wt(2);
    wr(REG_GAIN, 32'h00000100);
    wt(1000);
    cmp({16'h0, trim_o}, {16'h0, speed_cmd_in});
    $display("test loss done");
    close_out();
  end
endmodule // tb_efp_ctrl
